// [bench/lecnt_chk.sv]
// Port checks for the line error counter top.
`timescale 1ns/10ps
module lecnt_chk
  import lecnt_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire lecnt_cfg_t cfg_out,
  input wire logic       latch_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_cfg_wr; reg_wr && reg_addr == 8'h41; endsequence
  sequence s_rd_lo; reg_addr == 8'h43 && !latch_pulse; endsequence
  property p_cfg_wr;
    s_cfg_wr |=> {1'b0, cfg_out} == ($past(reg_wdata) & 8'h7F);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config lost");
  property p_cfg_hold; !(reg_wr && reg_addr == 8'h41) |=> $stable(cfg_out);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved");
  property p_manual; $rose(cfg_out.manual_latch_trigger)
    && cfg_out.accumulation_source_select |-> latch_pulse; endproperty
  a_manual: assert property (p_manual) else $error("no manual latch");
  property p_no_auto; cfg_out.accumulation_source_select
    && !$rose(cfg_out.manual_latch_trigger) |-> !latch_pulse; endproperty
  a_no_auto: assert property (p_no_auto) else $error("stray latch");
  property p_rd_cfg; reg_addr == 8'h41 |=> reg_rdata == {1'b0, $past(cfg_out)};
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read bad");
  property p_rd_none; reg_addr == 8'h44 |=> reg_rdata == 8'h00; endproperty
  a_rd_none: assert property (p_rd_none) else $error("unmapped read");
  property p_cnt_hold; s_rd_lo ##1 s_rd_lo |=> $stable(reg_rdata); endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("count moved");
  property p_auto_gap; !cfg_out.accumulation_source_select && latch_pulse
    |=> (!latch_pulse || cfg_out.accumulation_source_select) [*8]; endproperty
  a_auto_gap: assert property (p_auto_gap) else $error("early latch");
endmodule : lecnt_chk
bind lecnt_top lecnt_chk lecnt_chk_inst (.clk_sys, .srst, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rdata, .cfg_out, .latch_pulse);

// [bench/lecnt_line_model.sv]
// Receive line model: symbols on request and a free running frame tick.
`timescale 1ns/10ps
module lecnt_line_model
  import lecnt_pkg::*;
#(
  parameter int FRAME = 2
) (
  input  wire logic [1:0] req,
  input  wire logic       clk_sys,
  input  wire logic       cw,
  output lecnt_sym_t      sym,
  output logic            sym_valid,
  output logic            sub_codeword,
  output logic            frame_tick
);
  logic last_r = 1'b0;
  logic mark_nxt;
  int   fr_r = 0;
  // Request 1 sends a zero, 2 an alternating mark, 3 a repeated polarity.
  assign mark_nxt = req[0] ? last_r : !last_r;
  initial {sym, sym_valid, sub_codeword, frame_tick} = 5'h00;
  always @(posedge clk_sys) begin
    sym_valid    <= req != 2'h0;
    sub_codeword <= cw;
    if (req[1]) begin
      sym    <= {mark_nxt, !mark_nxt};
      last_r <= mark_nxt;
    end else begin
      sym    <= (req == 2'h1) ? 2'h0 : ~sym;
    end
    frame_tick <= fr_r == FRAME - 1;
    fr_r       <= (fr_r == FRAME - 1) ? 0 : fr_r + 1;
  end
endmodule : lecnt_line_model

// [bench/lecnt_top_tb.sv]
// Self-checking bench for the line error counter top.
`timescale 1ns/10ps
module lecnt_top_tb
  import lecnt_pkg::*;
;
  typedef struct packed {
    logic [7:0] c; logic e; logic d; logic [1:0] k; logic w; logic [7:0] n;
    logic [15:0] x;
  } lecnt_row_t;
  localparam int SEC = 200;
  localparam int FRM = 2;
  localparam lecnt_row_t ROWS [10] = '{
    '{8'h10, 0, 0, 3, 0, 5, 5}, '{8'h10, 0, 1, 3, 1, 4, 0},
    '{8'h11, 0, 0, 1, 0, 31, 1}, '{8'h11, 0, 1, 1, 0, 16, 2},
    '{8'h10, 0, 0, 1, 0, 16, 0}, '{8'h10, 1, 0, 3, 0, 3, 3},
    '{8'h10, 1, 1, 3, 1, 3, 0}, '{8'h18, 1, 0, 2, 0, 6, 0},
    '{8'h18, 1, 0, 3, 0, 3, 3}, '{8'h18, 1, 0, 3, 0, 3, 2}};
  logic       clk_sys = 0, srst = 1, reg_wr = 0, cw = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic       e1_mode = 0, sub_decode_en = 0, receive_sync_lost = 0;
  logic [1:0] req = 0;
  logic       sym_valid, sub_codeword, frame_tick, latch_pulse;
  lecnt_sym_t sym;
  lecnt_cfg_t cfg_out;
  int         err_count = 0, samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  lecnt_top #(.SECOND_CYCLES(SEC)) lecnt_top_inst (.clk_sys, .srst, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rdata, .sym_valid, .sym, .e1_mode, .sub_codeword,
    .sub_decode_en, .frame_tick, .receive_sync_lost, .cfg_out, .latch_pulse);
  lecnt_line_model #(.FRAME(FRM)) lecnt_line_model_inst (.clk_sys, .req, .cw,
    .sym, .sym_valid, .sub_codeword, .frame_tick);
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] ex);
    samples_checked++;
    if (got !== ex) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask : rd
  task automatic latch(input logic [7:0] c, output logic [15:0] v);
    wr(8'h41, c);
    wr(8'h41, c | 8'h40);
    rd(8'h42, v[15:8]);
    rd(8'h43, v[7:0]);
  endtask : latch
  task automatic send(input logic [1:0] k, input logic w, input int n);
    repeat (n) @(posedge clk_sys) {req, cw} <= {k, w};
    @(posedge clk_sys);
    {req, cw} <= 3'h0;
  endtask : send
  task automatic t_reset;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(8'h41 + 8'(i), d);
      chk({8'h00, d}, 16'h0000);
    end
    wr(8'h41, 8'hFF);
    rd(8'h41, d);
    chk({8'h00, d}, 16'h007F);
    $display("test reset done");
  endtask : t_reset
  task automatic t_rows;
    logic [15:0] v;
    foreach (ROWS[i]) begin
      @(posedge clk_sys);
      {e1_mode, sub_decode_en, receive_sync_lost} <= {ROWS[i].e, ROWS[i].d,
        i[0]};
      send(2'h2, 1'b0, 1);
      latch(ROWS[i].c, v);
      send(ROWS[i].k, ROWS[i].w, int'(ROWS[i].n));
      latch(ROWS[i].c, v);
      chk(v, ROWS[i].x);
    end
    $display("test counting done");
  endtask : t_rows
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (latch_pulse !== 1'b1 && n < 3000);
  endtask : gap
  task automatic t_auto;
    int n;
    int ex [3] = '{SEC, LECNT_T1_FRAMES * FRM, LECNT_E1_FRAMES * FRM};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      e1_mode <= i == 2;
      wr(8'h41, (i == 0) ? 8'h00 : 8'h20);
      gap(n);
      gap(n);
      chk(16'(n), 16'(ex[i]));
    end
    $display("test interval done");
  endtask : t_auto
  task automatic t_sat;
    logic [15:0] v;
    @(posedge clk_sys);
    {e1_mode, sub_decode_en} <= 2'h2;
    latch(8'h10, v);
    send(2'h3, 1'b0, 65540);
    latch(8'h10, v);
    chk(v, 16'hFFFF);
    wr(8'h42, 8'h00);
    rd(8'h42, v[15:8]);
    chk(v, 16'hFFFF);
    $display("test saturation done");
  endtask : t_sat
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_rows;
    t_auto;
    t_sat;
    final_report;
  end
  initial begin
    #(90000 * 10);
    err_count++;
    final_report;
  end
endmodule : lecnt_top_tb

// [design/lecnt_interval_timer.sv]
// Update interval timer giving one-second or frame-based latch pulses.
`timescale 1ns/10ps
module lecnt_interval_timer
  import lecnt_pkg::*;
#(
  parameter int SECOND_CYCLES = LECNT_SECOND_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic frame_tick,
  input  wire logic e1_mode,
  input  wire logic short_sel,
  output logic      interval_pulse
);
  logic [31:0] sec_cnt_r;
  logic [9:0]  frm_cnt_r;
  logic [9:0]  frm_limit;
  logic        sec_hit;
  logic        frm_hit;
  logic [1:0]  sel_prev_r;
  logic        sel_change;

  // Frame interval is 333 frames on T1, 500 on E1.
  assign frm_limit = e1_mode ? 10'(LECNT_E1_FRAMES)
                             : 10'(LECNT_T1_FRAMES);
  assign sec_hit = (sec_cnt_r == 32'(SECOND_CYCLES - 1));
  assign frm_hit = frame_tick && (10'(frm_cnt_r + 10'h001) >= frm_limit);
  // A new interval source restarts both counts, so the first pulse after
  // a change comes a full interval later and never straight away.
  assign sel_change = (sel_prev_r != {short_sel, e1_mode});
  assign interval_pulse = !sel_change && (short_sel ? frm_hit : sec_hit);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_prev_r <= 2'h0;
    end else begin
      sel_prev_r <= {short_sel, e1_mode};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || sel_change || sec_hit) begin
      sec_cnt_r <= 32'h00000000;
    end else begin
      sec_cnt_r <= 32'(sec_cnt_r + 32'h00000001);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || sel_change || frm_hit) begin
      frm_cnt_r <= 10'h000;
    end else if (frame_tick) begin
      frm_cnt_r <= 10'(frm_cnt_r + 10'h001);
    end
  end
endmodule : lecnt_interval_timer

// [design/lecnt_pkg.sv]
// Package of constants and types for the line error counter block.
// Overview of operation
// - Latch counts on second, frame interval, manual
// - Counters saturate at maximum, never wrap
// - Config bit 0 adds excessive zeros count
// - Config bit 1 selects out-of-sync count mode; stored, unused here
// - Config bit 2 adds Fs-bit path errors; stored, unused here
// - E1: bit 3 selects bipolar or code violations
// - Bit 4 picks automatic or manual latching
// - T1 auto: one second or 333 frames
// - E1 auto: one second or 500 frames
// - Manual bit rising latches next cycle, clears
// - T1 counts bipolar violations, skips B8ZS codewords
// - Line counter runs during sync loss
// - Zero threshold 16 plain, 8 with B8ZS
// - E1 same-polarity marks count, skip HDB3 codewords
// - E1 code violation: same-polarity successive violations
// - E1 counter holds at 65,535
// - Count high byte first register, low second
package lecnt_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] LECNT_ADDR_CONFIG   = 8'h41;
  localparam logic [7:0] LECNT_ADDR_CNT_HIGH = 8'h42;
  localparam logic [7:0] LECNT_ADDR_CNT_LOW  = 8'h43;
  localparam logic [7:0] LECNT_CONFIG_RESET  = 8'h00;
  localparam logic [7:0] LECNT_CONFIG_MASK   = 8'h7F;
  localparam logic [15:0] LECNT_COUNT_RESET  = 16'h0000;
  localparam int LECNT_BIT_ZERO_CNT   = 0;
  localparam int LECNT_BIT_SYNC_LOSS  = 1;
  localparam int LECNT_BIT_FS_REPORT  = 2;
  localparam int LECNT_BIT_VIOL_TYPE  = 3;
  localparam int LECNT_BIT_ACC_SRC    = 4;
  localparam int LECNT_BIT_AUTO_INT   = 5;
  localparam int LECNT_BIT_MANUAL     = 6;

  // ****************************************************************
  // Counting constants
  // ****************************************************************
  localparam int LECNT_ZEROS_PLAIN    = 16;
  localparam int LECNT_ZEROS_B8ZS     = 8;
  localparam int LECNT_T1_FRAMES      = 333;
  localparam int LECNT_E1_FRAMES      = 500;
  localparam int LECNT_SECOND_MS      = 1000;
  localparam int LECNT_CLK_MHZ        = 100;
  localparam int LECNT_SECOND_CYCLES  =
    LECNT_SECOND_MS * 1000 * LECNT_CLK_MHZ;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic manual_latch_trigger;
    logic auto_interval_select;
    logic accumulation_source_select;
    logic e1_violation_type_select;
    logic secondary_frame_bit_report;
    logic sync_loss_count_select;
    logic t1_zero_count_select;
  } lecnt_cfg_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } lecnt_sym_t;

  function automatic logic [15:0] lecnt_sat_inc(input logic [15:0] v);
    lecnt_sat_inc = (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
  endfunction : lecnt_sat_inc

endpackage : lecnt_pkg

// [design/lecnt_top.sv]
// Line error counter top: configuration register, counter and latch.
`timescale 1ns/10ps
module lecnt_top
  import lecnt_pkg::*;
#(
  parameter int SECOND_CYCLES = LECNT_SECOND_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       sym_valid,
  input  wire lecnt_sym_t sym,
  input  wire logic       e1_mode,
  input  wire logic       sub_decode_en,
  input  wire logic       sub_codeword,
  input  wire logic       frame_tick,
  input  wire logic       receive_sync_lost,
  output lecnt_cfg_t      cfg_out,
  output logic            latch_pulse
);
  lecnt_cfg_t  cfg_r;
  logic        manual_prev_r;
  logic [15:0] count_r;
  logic [15:0] latched_r;
  logic        viol_pulse;
  logic        interval_pulse;
  logic        manual_pulse;
  logic [7:0]  rdata_nxt;

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_r <= lecnt_cfg_t'(LECNT_CONFIG_RESET[6:0]);
    end else if (reg_wr && reg_addr == LECNT_ADDR_CONFIG) begin
      // Bit 7 is not stored; it reads back as zero.
      // Bits 1 and 2 are stored for read-back only; no counter here uses them.
      cfg_r <= lecnt_cfg_t'(reg_wdata[6:0]);
    end
  end

  assign cfg_out = cfg_r;

  // ****************************************************************
  // Update event selection
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      manual_prev_r <= 1'b0;
    end else begin
      manual_prev_r <= cfg_r.manual_latch_trigger;
    end
  end

  // The stored bit rises, and the latch follows on the next edge.
  assign manual_pulse = cfg_r.manual_latch_trigger && !manual_prev_r;

  lecnt_interval_timer #(
    .SECOND_CYCLES (SECOND_CYCLES)
  ) u_timer (
    .clk_sys        (clk_sys),
    .srst           (srst),
    .frame_tick     (frame_tick),
    .e1_mode        (e1_mode),
    .short_sel      (cfg_r.auto_interval_select),
    .interval_pulse (interval_pulse)
  );

  // Manual or automatic source chosen by the accumulation bit.
  assign latch_pulse = cfg_r.accumulation_source_select ? manual_pulse
                                                        : interval_pulse;

  // ****************************************************************
  // Violation detection and counting
  // ****************************************************************
  lecnt_viol_detect u_detect (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .sym_valid     (sym_valid),
    .sym           (sym),
    .e1_mode       (e1_mode),
    .sub_decode_en (sub_decode_en),
    .sub_codeword  (sub_codeword),
    .cfg           (cfg_r),
    .viol_pulse    (viol_pulse)
  );

  // The sync-loss input does not gate this counter.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_r <= LECNT_COUNT_RESET;
    end else if (latch_pulse) begin
      // A violation in the latch cycle starts the new interval.
      count_r <= viol_pulse ? 16'h0001 : LECNT_COUNT_RESET;
    end else if (viol_pulse) begin
      count_r <= lecnt_sat_inc(count_r);
    end
  end

  // Latched copy changes only on update events.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latched_r <= LECNT_COUNT_RESET;
    end else if (latch_pulse) begin
      latched_r <= viol_pulse ? lecnt_sat_inc(count_r) : count_r;
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  always_comb begin
    unique case (reg_addr)
      LECNT_ADDR_CONFIG:   rdata_nxt = {1'b0, cfg_r};
      LECNT_ADDR_CNT_HIGH: rdata_nxt = latched_r[15:8];
      LECNT_ADDR_CNT_LOW:  rdata_nxt = latched_r[7:0];
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule : lecnt_top

// [design/lecnt_viol_detect.sv]
// Line symbol violation detector for T1 and E1 receive data.
`timescale 1ns/10ps
module lecnt_viol_detect
  import lecnt_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       sym_valid,
  input  wire lecnt_sym_t sym,
  input  wire logic       e1_mode,
  input  wire logic       sub_decode_en,
  input  wire logic       sub_codeword,
  input  wire lecnt_cfg_t cfg,
  output logic            viol_pulse
);
  logic       last_pol_r;
  logic       last_bpv_pol_r;
  logic       mark_seen_r;
  logic       bpv_seen_r;
  logic       same_pol;
  logic [4:0] zero_run_r;
  logic       mark;
  logic       bpv;
  logic       zero_hit;
  logic [4:0] zero_limit;

  assign mark = sym.pos | sym.neg;
  // The first mark after reset has no predecessor and is never a violation.
  assign same_pol = sym_valid && mark && mark_seen_r
                    && (sym.pos == last_pol_r);
  // Same-polarity marks, with substitution codewords excluded.
  assign bpv = same_pol && !(sub_decode_en && sub_codeword);
  assign zero_limit = sub_decode_en ? 5'(LECNT_ZEROS_B8ZS)
                                    : 5'(LECNT_ZEROS_PLAIN);
  // Excessive zero detection counted only in T1.
  assign zero_hit = sym_valid && !mark && !e1_mode
                    && cfg.t1_zero_count_select
                    && (5'(zero_run_r + 5'h01) == zero_limit);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      last_pol_r  <= 1'b0;
      mark_seen_r <= 1'b0;
    end else if (sym_valid && mark) begin
      last_pol_r  <= sym.pos;
      mark_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      zero_run_r <= 5'h00;
    end else if (sym_valid) begin
      if (mark || zero_hit) begin
        zero_run_r <= 5'h00;
      end else if (zero_run_r != 5'h1F) begin
        zero_run_r <= 5'(zero_run_r + 5'h01);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      last_bpv_pol_r <= 1'b0;
      bpv_seen_r     <= 1'b0;
    end else if (same_pol) begin
      last_bpv_pol_r <= sym.pos;
      bpv_seen_r     <= 1'b1;
    end
  end

  always_comb begin
    if (e1_mode && cfg.e1_violation_type_select) begin
      // Code violation: violation of same polarity as the last one.
      viol_pulse = same_pol && bpv_seen_r
                   && (sym.pos == last_bpv_pol_r);
    end else begin
      viol_pulse = bpv || zero_hit;
    end
  end
endmodule : lecnt_viol_detect
